// >>> design/ibdd_datapath.sv
// Execution datapath: clear index high, index-pair compare, decimal
// adjust, decrement-and-branch and 16-by-8 divide.
// Assumes a sequencer on the same clock supplies operands with a start
// pulse and writes back the registered results when done pulses.
`timescale 1ns/1ns

// Notes on behaviour
// - Clear-index-high loads zero into the high index byte, clears V and N, sets Z, 1 cycle.
// - Index-pair compare subtracts a 16-bit operand from H:X and only updates flags.
// - Compare sets V on 16-bit signed overflow, N from bit 15, Z when all 16 bits are zero.
// - Compare sets C to the borrow out from index bit 15, operand bit 15 and result bit 15.
// - Decimal adjust fixes A and C from C and H, V undefined, N from bit 7, Z on zero.
// - Decimal adjust adds 00, 06, 60 or 66 and sets C whenever the upper 6 is added.
// - Decrement-and-branch decrements A, X or a memory byte, branches if nonzero, flags kept.
// - Divide without overflow or zero divisor puts H:A divided by X into A, the remainder into H, X unchanged.
// - Divide sets C on quotient overflow or zero divisor, else clears C; 7 cycles.
// - Divide sets Z only when the byte left in A is zero (the kept A on overflow) and keeps the other flags.
module ibdd_datapath (
    input  wire logic        clk,
    input  wire logic        ce,
    input  wire logic        srst,
    input  wire logic        start,
    input  wire logic [7:0]  opcode,
    input  wire logic        page_stack,
    input  wire logic [7:0]  acc_in,
    input  wire logic [15:0] hx_in,
    input  wire logic [15:0] mem_in,
    input  wire logic [15:0] pc_in,
    input  wire logic [7:0]  rel_in,
    input  wire logic        flag_v_in,
    input  wire logic        flag_h_in,
    input  wire logic        flag_n_in,
    input  wire logic        flag_z_in,
    input  wire logic        flag_c_in,
    output logic      [7:0]  acc_r,
    output logic      [15:0] hx_r,
    output logic      [15:0] pc_r,
    output logic      [7:0]  mem_wdata_r,
    output logic             mem_we_r,
    output logic             flag_v_r,
    output logic             flag_h_r,
    output logic             flag_n_r,
    output logic             flag_z_r,
    output logic             flag_c_r,
    output logic             branch_r,
    output logic             busy_r,
    output logic             done_r,
    output logic             illegal_r
);
    import ibdd_pkg::*;

    // Decode of the offered opcode
    wire          plain   = ~page_stack;

    wire          d_clear = plain & (opcode == IBDD_OP_CLEAR_HI);
    wire          d_cimm  = plain & (opcode == IBDD_OP_CMP_IMM);
    wire          d_cdir  = plain & (opcode == IBDD_OP_CMP_DIR);
    wire          d_adj   = plain & (opcode == IBDD_OP_ADJ);
    wire          d_ddir  = plain & (opcode == IBDD_OP_DEC_DIR);
    wire          d_dacc  = plain & (opcode == IBDD_OP_DEC_ACC);
    wire          d_didx  = plain & (opcode == IBDD_OP_DEC_IDX);
    wire          d_dix   = plain & (opcode == IBDD_OP_DEC_IX);
    wire          d_dix1  = plain & (opcode == IBDD_OP_DEC_IX1);
    wire          d_dsp1  = page_stack & (opcode == IBDD_OP_DEC_IX1);
    wire          d_div   = plain & (opcode == IBDD_OP_DIVIDE);

    wire          d_dec   = d_ddir | d_dacc | d_didx | d_dix | d_dix1 | d_dsp1;
    wire          d_cmp   = d_cimm | d_cdir;
    wire          d_known = d_clear | d_cmp | d_adj | d_dec | d_div;

    ibdd_cls_type d_cls;
    ibdd_src_type d_src;
    logic [2:0]   d_cyc;
    logic [15:0]  d_step;

    assign d_cls = d_clear ? IBDD_CLS_CLEAR :
                   d_cmp   ? IBDD_CLS_CMP   :
                   d_adj   ? IBDD_CLS_ADJ   :
                   d_dec   ? IBDD_CLS_DEC   :
                   d_div   ? IBDD_CLS_DIV   : IBDD_CLS_NONE;

    assign d_src = d_dacc ? IBDD_SRC_ACC :
                   d_didx ? IBDD_SRC_IDX : IBDD_SRC_MEM;

    // Cycle budget per form
    assign d_cyc = d_clear ? IBDD_CYC_CLEAR   :
                   d_cimm  ? IBDD_CYC_CMP_IMM :
                   d_cdir  ? IBDD_CYC_CMP_DIR :
                   d_adj   ? IBDD_CYC_ADJ     :
                   d_ddir  ? IBDD_CYC_DEC_DIR :
                   d_dix   ? IBDD_CYC_DEC_IX  :
                   d_dix1  ? IBDD_CYC_DEC_IX1 :
                   d_dsp1  ? IBDD_CYC_DEC_SP1 :
                   d_div   ? IBDD_CYC_DIVIDE  :
                   IBDD_CYC_DEC_INH;

    // Instruction length used as the branch base
    assign d_step = (d_ddir | d_dix1) ? IBDD_PC_STEP_3 :
                    d_dsp1            ? IBDD_PC_STEP_4 :
                    IBDD_PC_STEP_2;

    // Latched operands, held for the whole instruction
    ibdd_state_type state_r;
    ibdd_state_type state_nxt;

    ibdd_cls_type   cls_r;
    ibdd_src_type   src_r;
    logic [2:0]     cnt_r;
    logic [2:0]     cnt_nxt;

    logic [15:0]    step_r;
    logic [7:0]     acc_l_r;
    logic [15:0]    hx_l_r;
    logic [15:0]    mem_l_r;
    logic [15:0]    pc_l_r;
    logic [7:0]     rel_l_r;
    logic [4:0]     flg_l_r;

    // Start while busy is dropped, never queued
    wire take   = (state_r == IBDD_IDLE) & start;
    wire accept = take & d_known;
    wire reject = take & ~d_known;
    wire commit = (state_r == IBDD_EXEC) & (cnt_r == IBDD_CNT_ONE);

    // Starting count equals the form's total; commit lands on the last cycle
    assign cnt_nxt   = accept ? d_cyc :
                       (state_r == IBDD_EXEC) ? cnt_r - IBDD_CNT_ONE : cnt_r;
    assign state_nxt = accept ? IBDD_EXEC :
                       commit ? IBDD_IDLE : state_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= IBDD_IDLE;
            cnt_r   <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cls_r   <= IBDD_CLS_NONE;
            src_r   <= IBDD_SRC_ACC;
            step_r  <= IBDD_RST_WORD;
            acc_l_r <= IBDD_RST_BYTE;
            hx_l_r  <= IBDD_RST_WORD;
            mem_l_r <= IBDD_RST_WORD;
            pc_l_r  <= IBDD_RST_WORD;
            rel_l_r <= IBDD_RST_BYTE;
            flg_l_r <= '0;
        end else if (ce & accept) begin
            cls_r   <= d_cls;
            src_r   <= d_src;
            step_r  <= d_step;
            acc_l_r <= acc_in;
            hx_l_r  <= hx_in;
            mem_l_r <= mem_in;
            pc_l_r  <= pc_in;
            rel_l_r <= rel_in;
            flg_l_r <= {flag_v_in, flag_h_in, flag_n_in, flag_z_in, flag_c_in};
        end
    end

    // Flags as sampled at the take
    wire l_v = flg_l_r[4];
    wire l_h = flg_l_r[3];
    wire l_n = flg_l_r[2];
    wire l_z = flg_l_r[1];
    wire l_c = flg_l_r[0];

    // Index-pair compare; only flags leave this path
    wire [15:0] cmp_res = hx_l_r - mem_l_r;
    wire        ix15    = hx_l_r[15];
    wire        m15     = mem_l_r[15];
    wire        r15     = cmp_res[15];
    wire        cmp_v   = (ix15 & ~m15 & ~r15) | (~ix15 & m15 & r15);
    wire        cmp_c   = (~ix15 & m15) | (m15 & r15) | (r15 & ~ix15);
    wire        cmp_z   = (cmp_res == IBDD_RST_WORD);

    // Decimal adjust
    logic [7:0] adj_res;
    logic       adj_c;

    ibdd_dec_adjust u_adj (
        .acc       (acc_l_r),
        .carry_in  (l_c),
        .half_in   (l_h),
        .result    (adj_res),
        .carry_out (adj_c)
    );

    // Decrement and branch
    wire [7:0]  dec_src = (src_r == IBDD_SRC_ACC) ? acc_l_r :
                          (src_r == IBDD_SRC_IDX) ? hx_l_r[7:0] : mem_l_r[7:0];
    wire [7:0]  dec_res = dec_src - 8'h01;
    wire        dec_tk  = (dec_res != IBDD_RST_BYTE);
    // Signed offset, reach -128 to +127
    wire [15:0] rel_ext = {{8{rel_l_r[7]}}, rel_l_r};
    wire [15:0] pc_seq  = pc_l_r + step_r;
    wire [15:0] pc_br   = pc_seq + rel_ext;

    // Divide of H:A by X
    logic [7:0] div_q;
    logic [7:0] div_r;
    logic       div_ovf;

    ibdd_divider #(
        .W (8)
    ) u_div (
        .dvd_hi    (hx_l_r[15:8]),
        .dvd_lo    (acc_l_r),
        .divisor   (hx_l_r[7:0]),
        .quotient  (div_q),
        .remainder (div_r),
        .overflow  (div_ovf)
    );

    // Overflow keeps A and H: the results are indeterminate anyway
    wire [7:0] div_acc = div_ovf ? acc_l_r : div_q;
    wire [7:0] div_hi  = div_ovf ? hx_l_r[15:8] : div_r;

    // Result selection per class
    wire is_clr = (cls_r == IBDD_CLS_CLEAR);
    wire is_cmp = (cls_r == IBDD_CLS_CMP);
    wire is_adj = (cls_r == IBDD_CLS_ADJ);
    wire is_dec = (cls_r == IBDD_CLS_DEC);
    wire is_div = (cls_r == IBDD_CLS_DIV);

    wire [7:0]  res_acc = is_adj ? adj_res :
                          is_div ? div_acc :
                          (is_dec & (src_r == IBDD_SRC_ACC)) ? dec_res : acc_l_r;

    wire [7:0]  res_hi  = is_clr ? IBDD_RST_BYTE :
                          is_div ? div_hi : hx_l_r[15:8];

    wire [7:0]  res_lo  = (is_dec & (src_r == IBDD_SRC_IDX)) ? dec_res
                          : hx_l_r[7:0];
    wire [15:0] res_pc  = is_dec ? (dec_tk ? pc_br : pc_seq) : pc_l_r;

    // V is left as it was on decimal adjust, which is one legal undefined value
    wire res_v = is_clr ? 1'b0 :
                 is_cmp ? cmp_v : l_v;
    wire res_n = is_clr ? 1'b0 :
                 is_cmp ? r15 :
                 is_adj ? adj_res[7] : l_n;
    wire res_z = is_clr ? 1'b1 :
                 is_cmp ? cmp_z :
                 is_adj ? (adj_res == IBDD_RST_BYTE) :
                 is_div ? (div_acc == IBDD_RST_BYTE) : l_z;
    wire res_c = is_cmp ? cmp_c :
                 is_adj ? adj_c :
                 is_div ? div_ovf : l_c;

    // Only memory forms write back
    wire res_we = is_dec & (src_r == IBDD_SRC_MEM);

    // Architectural results; flags not named above pass unchanged
    always_ff @(posedge clk) begin
        if (srst) begin
            acc_r       <= IBDD_RST_BYTE;
            hx_r        <= IBDD_RST_WORD;
            pc_r        <= IBDD_RST_WORD;
            mem_wdata_r <= IBDD_RST_BYTE;
            flag_v_r    <= 1'b0;
            flag_h_r    <= 1'b0;
            flag_n_r    <= 1'b0;
            flag_z_r    <= 1'b0;
            flag_c_r    <= 1'b0;
        end else if (ce & commit) begin
            acc_r       <= res_acc;
            hx_r        <= {res_hi, res_lo};
            pc_r        <= res_pc;
            mem_wdata_r <= res_we ? dec_res : IBDD_RST_BYTE;
            flag_v_r    <= res_v;
            flag_h_r    <= l_h;
            flag_n_r    <= res_n;
            flag_z_r    <= res_z;
            flag_c_r    <= res_c;
        end
    end

    // Status pulses; held frozen when ce is low
    always_ff @(posedge clk) begin
        if (srst) begin
            busy_r    <= 1'b0;
            done_r    <= 1'b0;
            mem_we_r  <= 1'b0;
            branch_r  <= 1'b0;
            illegal_r <= 1'b0;
        end else if (ce) begin
            busy_r    <= (state_nxt == IBDD_EXEC);
            done_r    <= commit;
            mem_we_r  <= commit & res_we;
            branch_r  <= commit & is_dec & dec_tk;
            illegal_r <= reject;
        end
    end
endmodule

// >>> design/ibdd_dec_adjust.sv
// Decimal correction of an accumulator after a BCD addition.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module ibdd_dec_adjust (
    input  wire logic [7:0] acc,
    input  wire logic       carry_in,
    input  wire logic       half_in,
    output logic      [7:0] result,
    output logic            carry_out
);
    import ibdd_pkg::*;

    wire       lo_fix = half_in | (acc[3:0] > IBDD_NIB_MAX);
    // Upper fix covers all of the table's upper-nibble ranges
    wire       hi_fix = carry_in | (acc > IBDD_BYTE_MAX);
    wire [7:0] corr   = (lo_fix ? IBDD_ADJ_LO : IBDD_RST_BYTE)
                      | (hi_fix ? IBDD_ADJ_HI : IBDD_RST_BYTE);

    assign result    = acc + corr;
    assign carry_out = carry_in | hi_fix;
endmodule

// >>> design/ibdd_divider.sv
// Unsigned restoring divide of a 2W-bit dividend by a W-bit divisor.
// Combinational array; overflow and zero divisor are flagged, not solved.
`timescale 1ns/1ns
module ibdd_divider #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] dvd_hi,
    input  wire logic [W-1:0] dvd_lo,
    input  wire logic [W-1:0] divisor,
    output logic      [W-1:0] quotient,
    output logic      [W-1:0] remainder,
    output logic              overflow
);
    if (W < 2) begin : g_bad_width
        $error("ibdd_divider: W must be at least 2");
    end

    logic [W-1:0] rem_s [0:W];

    assign rem_s[0] = dvd_hi;
    // Quotient fits only if the high half is below the divisor
    assign overflow = (divisor == '0) | (dvd_hi >= divisor);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_step
            wire [W:0] trial = {rem_s[i], dvd_lo[W-1-i]};
            wire       fits  = trial >= {1'b0, divisor};
            wire [W:0] diff  = trial - {1'b0, divisor};
            assign quotient[W-1-i] = fits;
            assign rem_s[i+1]      = fits ? diff[W-1:0] : trial[W-1:0];
        end
    endgenerate

    assign remainder = rem_s[W];
endmodule

// >>> include/ibdd_pkg.sv
// Shared constants and types for the index, BCD and divide datapath.
// Assumes one clock domain; opcodes arrive already fetched.
package ibdd_pkg;

    typedef enum logic [0:0] {
        IBDD_IDLE = 1'b0,
        IBDD_EXEC = 1'b1
    } ibdd_state_type;

    typedef enum logic [2:0] {
        IBDD_CLS_NONE  = 3'b000,
        IBDD_CLS_CLEAR = 3'b001,
        IBDD_CLS_CMP   = 3'b010,
        IBDD_CLS_ADJ   = 3'b011,
        IBDD_CLS_DEC   = 3'b100,
        IBDD_CLS_DIV   = 3'b101
    } ibdd_cls_type;

    typedef enum logic [1:0] {
        IBDD_SRC_ACC = 2'b00,
        IBDD_SRC_IDX = 2'b01,
        IBDD_SRC_MEM = 2'b10
    } ibdd_src_type;

    // Opcodes; the stack form of the decrement is a prefixed page
    localparam logic [7:0] IBDD_OP_CLEAR_HI = 8'h8C;
    localparam logic [7:0] IBDD_OP_CMP_IMM  = 8'h65;
    localparam logic [7:0] IBDD_OP_CMP_DIR  = 8'h75;
    localparam logic [7:0] IBDD_OP_ADJ      = 8'h72;
    localparam logic [7:0] IBDD_OP_DEC_DIR  = 8'h3B;
    localparam logic [7:0] IBDD_OP_DEC_ACC  = 8'h4B;
    localparam logic [7:0] IBDD_OP_DEC_IDX  = 8'h5B;
    localparam logic [7:0] IBDD_OP_DEC_IX   = 8'h7B;
    localparam logic [7:0] IBDD_OP_DEC_IX1  = 8'h6B;
    localparam logic [7:0] IBDD_OP_DIVIDE   = 8'h52;

    // Cycle counts per addressing form
    localparam logic [2:0] IBDD_CYC_CLEAR   = 3'h1;
    localparam logic [2:0] IBDD_CYC_CMP_IMM = 3'h3;
    localparam logic [2:0] IBDD_CYC_CMP_DIR = 3'h4;
    localparam logic [2:0] IBDD_CYC_ADJ     = 3'h2;
    localparam logic [2:0] IBDD_CYC_DEC_DIR = 3'h5;
    localparam logic [2:0] IBDD_CYC_DEC_INH = 3'h3;
    localparam logic [2:0] IBDD_CYC_DEC_IX  = 3'h4;
    localparam logic [2:0] IBDD_CYC_DEC_IX1 = 3'h5;
    localparam logic [2:0] IBDD_CYC_DEC_SP1 = 3'h6;
    localparam logic [2:0] IBDD_CYC_DIVIDE  = 3'h7;

    // Program counter steps of the decrement forms
    localparam logic [15:0] IBDD_PC_STEP_2 = 16'h0002;
    localparam logic [15:0] IBDD_PC_STEP_3 = 16'h0003;
    localparam logic [15:0] IBDD_PC_STEP_4 = 16'h0004;

    // Decimal correction
    localparam logic [7:0] IBDD_ADJ_LO   = 8'h06;
    localparam logic [7:0] IBDD_ADJ_HI   = 8'h60;
    localparam logic [3:0] IBDD_NIB_MAX  = 4'h9;
    localparam logic [7:0] IBDD_BYTE_MAX = 8'h99;

    localparam logic [7:0]  IBDD_RST_BYTE = 8'h00;
    localparam logic [15:0] IBDD_RST_WORD = 16'h0000;
    localparam logic [2:0]  IBDD_CNT_ONE  = 3'h1;

endpackage

// >>> verif/ibdd_datapath_checker.sv
// Concurrent checks on the datapath ports, bound into the top module.
// Assumes ce stays high while an instruction is in flight.
`timescale 1ns/1ns
module ibdd_datapath_checker (
    input wire logic        clk,
    input wire logic        ce,
    input wire logic        srst,
    input wire logic        start,
    input wire logic [7:0]  opcode,
    input wire logic        page_stack,
    input wire logic [7:0]  acc_in,
    input wire logic [15:0] hx_in,
    input wire logic [15:0] mem_in,
    input wire logic [15:0] pc_in,
    input wire logic [7:0]  rel_in,
    input wire logic        flag_v_in,
    input wire logic        flag_h_in,
    input wire logic        flag_n_in,
    input wire logic        flag_z_in,
    input wire logic        flag_c_in,
    input wire logic [7:0]  acc_r,
    input wire logic [15:0] hx_r,
    input wire logic [15:0] pc_r,
    input wire logic        flag_v_r,
    input wire logic        flag_h_r,
    input wire logic        flag_n_r,
    input wire logic        flag_z_r,
    input wire logic        flag_c_r,
    input wire logic        branch_r,
    input wire logic        busy_r,
    input wire logic        done_r
);
    import ibdd_pkg::*;
    // Stack form excluded: page_stack selects the stack decrement and makes every other opcode illegal
    wire        take    = ce && !srst && !busy_r && start && !page_stack;
    wire [16:0] cmp_d   = {1'b0, hx_in} - {1'b0, mem_in};
    wire        cmp_v   = (hx_in[15] ^ mem_in[15]) & (hx_in[15] ^ cmp_d[15]);
    wire [3:0]  cmp_f   = {cmp_v, cmp_d[15], cmp_d[15:0] == 16'h0000, cmp_d[16]};
    wire [3:0]  cmp_o   = {flag_v_r, flag_n_r, flag_z_r, flag_c_r};
    wire [4:0]  fl_in   = {flag_v_in, flag_h_in, flag_n_in, flag_z_in, flag_c_in};
    wire [4:0]  fl_o    = {flag_v_r, flag_h_r, flag_n_r, flag_z_r, flag_c_r};
    wire [7:0]  x_in    = hx_in[7:0];
    wire [7:0]  x_dec   = x_in - 8'h01;
    wire        div_ovf = x_in == 8'h00 || hx_in[15:8] >= x_in;
    wire [15:0] dec_pc  = pc_in + IBDD_PC_STEP_2 + {{8{rel_in[7]}}, rel_in};

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_busy3_done;
        (busy_r && !done_r)[*3] ##1 done_r && !busy_r;
    endsequence
    sequence s_div_run;
        (busy_r && !done_r)[*7] ##1 done_r;
    endsequence

    property p_clear;
        take && opcode == IBDD_OP_CLEAR_HI |-> ##2 done_r && hx_r[15:8] == 8'h00
            && !flag_v_r && !flag_n_r && flag_z_r;
    endproperty
    a_clear: assert property (p_clear) else $error("clear result wrong");
    property p_adj;
        take && opcode == IBDD_OP_ADJ |=> (!done_r)[*2] ##1 done_r && flag_n_r == acc_r[7]
            && flag_z_r == (acc_r == 8'h00);
    endproperty
    a_adj: assert property (p_adj) else $error("adjust timing or flags wrong");
    property p_cmp_flags;
        take && opcode == IBDD_OP_CMP_IMM |-> ##4 done_r && cmp_o == $past(cmp_f, 4);
    endproperty
    a_cmp_flags: assert property (p_cmp_flags) else $error("compare flags wrong");
    property p_cmp_keep;
        take && opcode == IBDD_OP_CMP_DIR |-> ##5 done_r && hx_r == $past(hx_in, 5);
    endproperty
    a_cmp_keep: assert property (p_cmp_keep) else $error("compare changed index");
    property p_div;
        take && opcode == IBDD_OP_DIVIDE |=> s_div_run ##0 flag_c_r == $past(div_ovf, 8)
            && hx_r[7:0] == $past(x_in, 8) && flag_z_r == (acc_r == 8'h00);
    endproperty
    a_div: assert property (p_div) else $error("divide timing or flags wrong");
    property p_dec_flags;
        take && opcode == IBDD_OP_DEC_ACC |=> s_busy3_done ##0 fl_o == $past(fl_in, 4);
    endproperty
    a_dec_flags: assert property (p_dec_flags) else $error("decrement moved flags");
    property p_dec_branch;
        take && opcode == IBDD_OP_DEC_IDX && x_in != 8'h01 |-> ##4 branch_r
            && pc_r == $past(dec_pc, 4) && hx_r[7:0] == $past(x_dec, 4);
    endproperty
    a_dec_branch: assert property (p_dec_branch) else $error("branch target wrong");
    property p_branch_done;
        branch_r |-> done_r;
    endproperty
    a_branch_done: assert property (p_branch_done) else $error("branch without done");
endmodule

// >>> verif/ibdd_datapath_test.sv
// Self-checking bench for the datapath: random operands plus corners.
// Assumes the checker file is compiled first; ce is held high.
`timescale 1ns/1ns
bind ibdd_datapath ibdd_datapath_checker i_ibdd_datapath_checker (
    .clk, .ce, .srst, .start, .opcode, .page_stack, .acc_in, .hx_in, .mem_in, .pc_in,
    .rel_in, .flag_v_in, .flag_h_in, .flag_n_in, .flag_z_in, .flag_c_in, .acc_r, .hx_r,
    .pc_r, .flag_v_r, .flag_h_r, .flag_n_r, .flag_z_r, .flag_c_r, .branch_r, .busy_r, .done_r
);
module ibdd_datapath_test;
    import ibdd_pkg::*;
    localparam int          MAX_CYCLES = 20000;
    localparam logic [7:0]  F_OP [6]   = '{IBDD_OP_DEC_DIR, IBDD_OP_DEC_ACC, IBDD_OP_DEC_IDX,
                                           IBDD_OP_DEC_IX, IBDD_OP_DEC_IX1, IBDD_OP_DEC_IX1};
    localparam logic [2:0]  F_CYC [6]  = '{IBDD_CYC_DEC_DIR, IBDD_CYC_DEC_INH, IBDD_CYC_DEC_INH,
                                           IBDD_CYC_DEC_IX, IBDD_CYC_DEC_IX1, IBDD_CYC_DEC_SP1};
    localparam logic [15:0] F_STEP [6] = '{IBDD_PC_STEP_3, IBDD_PC_STEP_2, IBDD_PC_STEP_2,
                                           IBDD_PC_STEP_2, IBDD_PC_STEP_3, IBDD_PC_STEP_4};
    localparam int          F_SRC [6]  = '{2, 0, 1, 2, 2, 2};
    logic        clk, ce, srst, start, page_stack;
    logic [7:0]  opcode, acc_in, rel_in, r_a, r_rel;
    logic [15:0] hx_in, mem_in, pc_in, r_hx, r_m, r_pc;
    logic [4:0]  fl_in, r_fl;
    wire  [7:0]  acc_r, mem_wdata_r;
    wire  [15:0] hx_r, pc_r;
    wire  [4:0]  fl_r;
    wire         mem_we_r, branch_r, busy_r, done_r, illegal_r;
    int          n_errors, samples_checked, cycles;

    ibdd_datapath i_ibdd_datapath (
        .clk(clk), .ce(ce), .srst(srst), .start(start), .opcode(opcode),
        .page_stack(page_stack), .acc_in(acc_in), .hx_in(hx_in), .mem_in(mem_in),
        .pc_in(pc_in), .rel_in(rel_in), .flag_v_in(fl_in[4]), .flag_h_in(fl_in[3]),
        .flag_n_in(fl_in[2]), .flag_z_in(fl_in[1]), .flag_c_in(fl_in[0]), .acc_r(acc_r),
        .hx_r(hx_r), .pc_r(pc_r), .mem_wdata_r(mem_wdata_r), .mem_we_r(mem_we_r),
        .flag_v_r(fl_r[4]), .flag_h_r(fl_r[3]), .flag_n_r(fl_r[2]), .flag_z_r(fl_r[1]),
        .flag_c_r(fl_r[0]), .branch_r(branch_r), .busy_r(busy_r), .done_r(done_r),
        .illegal_r(illegal_r));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rnd();
        r_a = 8'($urandom);
        r_hx = 16'($urandom);
        r_m = 16'($urandom);
        r_pc = 16'($urandom);
        r_rel = 8'($urandom);
        r_fl = 5'($urandom);
    endtask
    task automatic apply();
        @(negedge clk);
        acc_in = r_a;
        hx_in = r_hx;
        mem_in = r_m;
        pc_in = r_pc;
        rel_in = r_rel;
        fl_in = r_fl;
    endtask
    // Hold mode keeps start up with another opcode to prove it is refused
    task automatic run_op(input logic [7:0] op, input logic ps, input logic hold, output int n);
        opcode = op;
        page_stack = ps;
        start = 1'b1;
        @(posedge clk);
        #1;
        n = 0;
        while (done_r !== 1'b1 && n < 12) begin
            @(negedge clk);
            if (hold) opcode = IBDD_OP_CLEAR_HI;
            else start = 1'b0;
            @(posedge clk);
            #1;
            n++;
        end
        @(negedge clk);
        start = 1'b0;
        page_stack = 1'b0;
    endtask
    function automatic logic [8:0] exp_adj(input logic [7:0] a, input logic c, input logic h);
        logic lo, hi;
        lo = h || a[3:0] > 4'h9;
        hi = c || a[7:4] > 4'h9 || (a[7:4] == 4'h9 && a[3:0] > 4'h9);
        return {hi, a + (hi ? IBDD_ADJ_HI : 8'h00) + (lo ? IBDD_ADJ_LO : 8'h00)};
    endfunction

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles >= MAX_CYCLES) begin
            n_errors++;
            conclude();
        end
    end

    initial begin
        int n;
        logic [16:0] d;
        logic [8:0]  e;
        logic [7:0]  v, r;
        logic [15:0] q, rm, epc;
        logic        ovf;
        ce = 1'b1;
        srst = 1'b1;
        start = 1'b0;
        page_stack = 1'b0;
        opcode = 8'h00;
        {acc_in, rel_in, hx_in, mem_in, pc_in, fl_in} = '0;
        void'($urandom(15841));
        repeat (8) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        for (int t = 0; t < 20; t++) begin
            rnd();
            apply();
            run_op(IBDD_OP_CLEAR_HI, 1'b0, 1'b0, n);
            check("clear cycles", 16'(IBDD_CYC_CLEAR), 16'(n));
            check("clear hx", {8'h00, r_hx[7:0]}, hx_r);
            check("clear flags", 16'({1'b0, r_fl[3], 2'b01, r_fl[0]}), 16'(fl_r));
        end
        $display("test clear done");
        for (int t = 0; t < 40; t++) begin
            rnd();
            if (t == 0) r_m = r_hx;
            if (t == 1) {r_hx, r_m} = {16'h8000, 16'h0001};
            if (t == 2) {r_hx, r_m} = {16'h0000, 16'hFFFF};
            apply();
            run_op(t[0] ? IBDD_OP_CMP_DIR : IBDD_OP_CMP_IMM, 1'b0, 1'b0, n);
            d = {1'b0, r_hx} - {1'b0, r_m};
            check("cmp cycles", 16'(t[0] ? IBDD_CYC_CMP_DIR : IBDD_CYC_CMP_IMM), 16'(n));
            check("cmp hx", r_hx, hx_r);
            check("cmp acc", 16'(r_a), 16'(acc_r));
            check("cmp write", 16'h0000, 16'(mem_we_r));
            check("cmp flags", 16'({(r_hx[15] ^ r_m[15]) & (r_hx[15] ^ d[15]), r_fl[3], d[15],
                d[15:0] == 16'h0000, d[16]}), 16'(fl_r));
        end
        $display("test compare done");
        for (int t = 0; t < 40; t++) begin
            rnd();
            if (t == 0) {r_a, r_fl[3], r_fl[0]} = {8'hC1, 1'b1, 1'b0};
            apply();
            run_op(IBDD_OP_ADJ, 1'b0, 1'b0, n);
            e = exp_adj(r_a, r_fl[0], r_fl[3]);
            check("adj cycles", 16'(IBDD_CYC_ADJ), 16'(n));
            check("adj acc", 16'(e[7:0]), 16'(acc_r));
            check("adj flags", 16'({r_fl[4:3], e[7], e[7:0] == 8'h00, e[8]}), 16'(fl_r));
        end
        $display("test adjust done");
        for (int f = 0; f < 6; f++) begin
            for (int t = 0; t < 8; t++) begin
                rnd();
                v = (t == 0) ? 8'h01 : (t == 1) ? 8'h00 : 8'($urandom);
                case (F_SRC[f])
                    0: r_a = v;
                    1: r_hx[7:0] = v;
                    default: r_m[7:0] = v;
                endcase
                apply();
                run_op(F_OP[f], f == 5, 1'b0, n);
                r = v - 8'h01;
                epc = r_pc + F_STEP[f] + ((r != 8'h00) ? {{8{r_rel[7]}}, r_rel} : 16'h0000);
                check("dec cycles", 16'(F_CYC[f]), 16'(n));
                check("dec pc", epc, pc_r);
                check("dec branch", 16'(r != 8'h00), 16'(branch_r));
                check("dec flags", 16'(r_fl), 16'(fl_r));
                check("dec acc", 16'(F_SRC[f] == 0 ? r : r_a), 16'(acc_r));
                check("dec hx", F_SRC[f] == 1 ? {r_hx[15:8], r} : r_hx, hx_r);
                check("dec write", 16'(F_SRC[f] == 2), 16'(mem_we_r));
                if (F_SRC[f] == 2) check("dec wdata", 16'(r), 16'(mem_wdata_r));
            end
        end
        $display("test decrement done");
        for (int t = 0; t < 40; t++) begin
            rnd();
            if (t[0]) r_hx[15:8] = 8'h00;
            if (t == 0) r_hx[7:0] = 8'h00;
            if (t == 2) r_hx = 16'h0505;
            if (t == 3) {r_hx, r_a} = {16'h00FF, 8'h00};
            apply();
            run_op(IBDD_OP_DIVIDE, 1'b0, t == 4, n);
            ovf = r_hx[7:0] == 8'h00 || r_hx[15:8] >= r_hx[7:0];
            q = ovf ? 16'(r_a) : {r_hx[15:8], r_a} / {8'h00, r_hx[7:0]};
            rm = ovf ? 16'(r_hx[15:8]) : {r_hx[15:8], r_a} % {8'h00, r_hx[7:0]};
            check("div cycles", 16'(IBDD_CYC_DIVIDE), 16'(n));
            check("div acc", 16'(q[7:0]), 16'(acc_r));
            check("div hx", {rm[7:0], r_hx[7:0]}, hx_r);
            check("div flags", 16'({r_fl[4:2], q[7:0] == 8'h00, ovf}), 16'(fl_r));
        end
        $display("test divide done");
        @(negedge clk);
        opcode = 8'h00;
        start = 1'b1;
        @(posedge clk);
        #1;
        check("illegal flag", 16'h0001, 16'(illegal_r));
        check("illegal done", 16'h0000, 16'({done_r, busy_r}));
        @(negedge clk);
        start = 1'b0;
        $display("test illegal done");
        conclude();
    end
endmodule
